//--- pmcg_power_mode_clock_gating.v
// Power mode sequencer: gates core and peripheral clocks and the oscillator.
// Assumes the core, interrupt unit and refresh unit share clk; hold request,
// non-maskable interrupt and oscillator stable arrive asynchronously.
// Functional notes
// - Armed mode entered only on halt
// - Both or neither armed: stay active
// - Idle freezes core clock, peripherals run
// - Idle refresh: start, idle state, run, idle
// - Ready, waits, chip selects live in refresh
// - Hold restarts core, acknowledge one later
// - Hold removed: acknowledge drops as core stops
// - Pending refresh withdraws hold acknowledge
// - Unmasked interrupt exits idle for good
// - Interrupt: start after seven, acknowledge six
// - Interrupt service leaves control register alone
// - NMI in idle: restart two, vector six
// - NMI exit leaves control register unchanged
// - Reset: active mode, register cleared
// - Powerdown stops all clocks and oscillator
// - Powerdown ignores hold and refresh
// - Halt second state stops clocks, oscillator next
// - Clock input isolated during powerdown
// - Clock output held high in powerdown
// - NMI wakes oscillator, gate after stable
// - Stable: one cycle, clocks, two, six
// - Arming bits reset zero, request next halt
`include "pmcg_consts.vh"

module pmcg_power_mode_clock_gating #(
    parameter [3:0] CLOCK_OUTPUT_HALF = 4'h1 // Clk cycles per clock output half period
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Core side: halt cycle and power control register write
    input wire halt_t2,
    input wire pcr_wr,
    input wire [`PMCG_PCR_W-1:0] pcr_wdata,
    output wire [`PMCG_PCR_W-1:0] power_control_reg,
    // Clock gating enables
    output wire core_clk_en,
    output wire periph_clk_en,
    output wire ready_cs_clk_en,
    output wire clock_output,
    // Oscillator control
    output wire osc_enable,
    output wire osc_delay_pin,
    output wire clock_input_isolate,
    input wire oscillator_stable,
    // Refresh unit and bus interface unit
    output wire refresh_tick,
    input wire refresh_req,
    output wire refresh_go,
    input wire refresh_done,
    // Bus hold
    input wire bus_hold_req,
    output wire bus_hold_ack,
    // Interrupts
    input wire irq_unmasked_req,
    output wire irq_acknowledge,
    input wire nmi_req,
    output wire nmi_to_core,
    output wire nmi_vector_fetch,
    output wire [`PMCG_ADDR_W-1:0] nmi_vector_addr,
    // Mode indication
    output wire mode_idle,
    output wire mode_powerdown
);

    // One-hot sequencer states
    localparam [19:0] S_ACTIVE = 20'h0_0001;
    localparam [19:0] S_IDLE = 20'h0_0002;
    localparam [19:0] S_REF_WAIT = 20'h0_0004;
    localparam [19:0] S_REF_T0 = 20'h0_0008;
    localparam [19:0] S_REF_RUN = 20'h0_0010;
    localparam [19:0] S_REF_TI = 20'h0_0020;
    localparam [19:0] S_HOLD_START = 20'h0_0040;
    localparam [19:0] S_HOLD_CORE = 20'h0_0080;
    localparam [19:0] S_HOLD_ON = 20'h0_0100;
    localparam [19:0] S_HOLD_REF = 20'h0_0200;
    localparam [19:0] S_HOLD_END = 20'h0_0400;
    localparam [19:0] S_IRQ_WAIT = 20'h0_0800;
    localparam [19:0] S_IRQ_RESP = 20'h0_1000;
    localparam [19:0] S_NMI_WAIT = 20'h0_2000;
    localparam [19:0] S_NMI_RESP = 20'h0_4000;
    localparam [19:0] S_PD_ENTER = 20'h0_8000;
    localparam [19:0] S_PD = 20'h1_0000;
    localparam [19:0] S_PD_OSC = 20'h2_0000;
    localparam [19:0] S_PD_RUN = 20'h4_0000;
    localparam [19:0] S_PD_NMI = 20'h8_0000;

    // State groups used by the gating outputs
    localparam [19:0] G_CORE_ON = S_ACTIVE | S_REF_T0 | S_REF_RUN | S_REF_TI |
        S_HOLD_CORE | S_HOLD_ON | S_HOLD_REF | S_HOLD_END |
        S_IRQ_RESP | S_NMI_RESP | S_PD_NMI;
    localparam [19:0] G_PERIPH_OFF = S_PD_ENTER | S_PD | S_PD_OSC | S_PD_RUN;
    localparam [19:0] G_FREEZE = S_PD | S_PD_OSC;
    localparam [19:0] G_OSC_OFF = S_PD | S_PD_OSC;
    localparam [19:0] G_IDLE = S_IDLE | S_REF_WAIT | S_REF_T0 | S_REF_RUN |
        S_REF_TI | S_HOLD_START | S_HOLD_CORE | S_HOLD_ON | S_HOLD_REF |
        S_HOLD_END | S_IRQ_WAIT | S_NMI_WAIT;

    // True when the state lies in a group
    function in_grp;
        input [19:0] st;
        input [19:0] grp;
        begin
            in_grp = |(st & grp);
        end
    endfunction

    // Sequencer and counters
    reg [19:0] state_r; // Current sequencer state
    reg [19:0] state_nxt; // Next sequencer state
    reg [`PMCG_CNT_W-1:0] cnt_r; // Clock output cycles spent in this state
    reg [`PMCG_CNT_W-1:0] cnt_nxt;
    reg [`PMCG_PCR_W-1:0] pcr_r; // Arming bits
    reg [`PMCG_ADDR_W-1:0] vec_r; // Vector address presented at fetch

    // Clock output divider
    reg [`PMCG_DIV_W-1:0] div_r; // Half period counter
    reg clock_output_r; // Clock output level

    // Synchronisers for asynchronous inputs
    reg hold_m_r;
    reg hold_s_r;
    reg nmi_m_r;
    reg nmi_s_r;
    reg osc_m_r;
    reg osc_s_r;

    // Strobes from the sequencer
    reg ref_go_nxt; // Start of refresh bus cycle
    reg irq_ack_nxt; // Start of interrupt acknowledge
    reg nmi_pres_nxt; // Interrupt handed to core
    reg nmi_fetch_nxt; // Vector fetch begins

    wire freeze; // Clock output held high
    wire div_wrap; // Half period ends this cycle
    wire tick_fall; // Clock output falls at this edge
    wire tick_rise; // Clock output rises at this edge
    wire [`PMCG_DIV_W-1:0] div_last;

    assign div_last = CLOCK_OUTPUT_HALF - `PMCG_DIV_ONE;

    assign freeze = in_grp(state_r, G_FREEZE);
    assign div_wrap = (div_r == div_last);
    assign tick_fall = !freeze && div_wrap && clock_output_r;
    assign tick_rise = !freeze && div_wrap && !clock_output_r;

    // Clock output divider; held high while frozen so the pin sits at one
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_r <= `PMCG_DIV_ZERO;
            clock_output_r <= `PMCG_CLOCK_OUTPUT_RESET;
        end else if (freeze) begin
            div_r <= `PMCG_DIV_ZERO;
            clock_output_r <= 1'b1;
        end else if (div_wrap) begin
            div_r <= `PMCG_DIV_ZERO;
            clock_output_r <= ~clock_output_r;
        end else begin
            div_r <= div_r + `PMCG_DIV_ONE;
        end
    end

    // Two-flop synchronisers; only the second stage is read by logic
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold_m_r <= 1'b0;
            hold_s_r <= 1'b0;
            nmi_m_r <= 1'b0;
            nmi_s_r <= 1'b0;
            osc_m_r <= 1'b0;
            osc_s_r <= 1'b0;
        end else begin
            hold_m_r <= bus_hold_req;
            hold_s_r <= hold_m_r;
            nmi_m_r <= nmi_req;
            nmi_s_r <= nmi_m_r;
            osc_m_r <= oscillator_stable;
            osc_s_r <= osc_m_r;
        end
    end

    // Arming bits; only an explicit write or reset changes them
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pcr_r <= `PMCG_PCR_RESET;
        end else if (pcr_wr) begin
            pcr_r <= pcr_wdata;
        end
    end

    // Next state; every timed wait counts clock output falling edges, except powerdown entry, which waits for a rising edge
    always @* begin
        state_nxt = state_r;
        ref_go_nxt = 1'b0;
        irq_ack_nxt = 1'b0;
        nmi_pres_nxt = 1'b0;
        nmi_fetch_nxt = 1'b0;
        case (state_r)
            S_ACTIVE: begin
                if (halt_t2) begin
                    if (pcr_r == `PMCG_ARM_IDLE_ONLY) begin
                        state_nxt = S_IDLE;
                    end else if (pcr_r == `PMCG_ARM_PD_ONLY) begin
                        state_nxt = S_PD_ENTER;
                    end
                end
            end
            S_IDLE: begin
                // Wake sources in priority order
                if (nmi_s_r) begin
                    state_nxt = S_NMI_WAIT;
                end else if (irq_unmasked_req) begin
                    state_nxt = S_IRQ_WAIT;
                end else if (hold_s_r) begin
                    state_nxt = S_HOLD_START;
                end else if (refresh_req) begin
                    state_nxt = S_REF_WAIT;
                end
            end
            S_REF_WAIT: begin
                if (tick_fall) begin
                    state_nxt = S_REF_T0;
                end
            end
            S_REF_T0: begin
                if (tick_fall && cnt_r == `PMCG_IDLE_TSTATE_CYC - `PMCG_CNT_ONE) begin
                    ref_go_nxt = 1'b1;
                    state_nxt = S_REF_RUN;
                end
            end
            S_REF_RUN: begin
                // Bus unit runs the dummy read with its own wait states
                if (refresh_done) begin
                    state_nxt = S_REF_TI;
                end
            end
            S_REF_TI: begin
                if (tick_fall && cnt_r == `PMCG_IDLE_TSTATE_CYC - `PMCG_CNT_ONE) begin
                    state_nxt = S_IDLE;
                end
            end
            S_HOLD_START: begin
                if (tick_fall && cnt_r == `PMCG_HOLD_START_CYC - `PMCG_CNT_ONE) begin
                    state_nxt = S_HOLD_CORE;
                end
            end
            S_HOLD_CORE: begin
                if (tick_fall && cnt_r == `PMCG_HOLD_ACK_CYC - `PMCG_CNT_ONE) begin
                    state_nxt = S_HOLD_ON;
                end
            end
            S_HOLD_ON: begin
                if (refresh_req) begin
                    ref_go_nxt = 1'b1;
                    state_nxt = S_HOLD_REF;
                end else if (!hold_s_r) begin
                    state_nxt = S_HOLD_END;
                end
            end
            S_HOLD_REF: begin
                // Re-acknowledge through the core start path once refreshed
                if (refresh_done) begin
                    state_nxt = hold_s_r ? S_HOLD_CORE : S_REF_TI;
                end
            end
            S_HOLD_END: begin
                if (tick_fall && cnt_r == `PMCG_HOLD_END_CYC - `PMCG_CNT_ONE) begin
                    state_nxt = S_IDLE;
                end
            end
            S_IRQ_WAIT: begin
                if (tick_fall && cnt_r == `PMCG_IRQ_START_CYC - `PMCG_CNT_ONE) begin
                    state_nxt = S_IRQ_RESP;
                end
            end
            S_IRQ_RESP: begin
                if (tick_fall && cnt_r == `PMCG_IRQ_RESP_CYC - `PMCG_CNT_ONE) begin
                    irq_ack_nxt = 1'b1;
                    state_nxt = S_ACTIVE;
                end
            end
            S_NMI_WAIT: begin
                if (tick_fall && cnt_r == `PMCG_NMI_START_CYC - `PMCG_CNT_ONE) begin
                    nmi_pres_nxt = 1'b1;
                    state_nxt = S_NMI_RESP;
                end
            end
            S_NMI_RESP: begin
                if (tick_fall && cnt_r == `PMCG_NMI_RESP_CYC - `PMCG_CNT_ONE) begin
                    nmi_fetch_nxt = 1'b1;
                    state_nxt = S_ACTIVE;
                end
            end
            S_PD_ENTER: begin
                if (tick_rise) begin
                    state_nxt = S_PD;
                end
            end
            S_PD: begin
                if (nmi_s_r) begin
                    state_nxt = S_PD_OSC;
                end
            end
            S_PD_OSC: begin
                if (osc_s_r) begin
                    state_nxt = S_PD_RUN;
                end
            end
            S_PD_RUN: begin
                if (tick_fall && cnt_r == `PMCG_PD_RUN_CYC - `PMCG_CNT_ONE) begin
                    state_nxt = S_PD_NMI;
                end
            end
            S_PD_NMI: begin
                if (tick_fall && cnt_r == `PMCG_PD_PRESENT_CYC - `PMCG_CNT_ONE) begin
                    nmi_pres_nxt = 1'b1;
                    state_nxt = S_NMI_RESP;
                end
            end
            default: begin
                state_nxt = S_ACTIVE;
            end
        endcase
    end

    // Cycle counter restarts on every state change
    always @* begin
        if (state_nxt != state_r) begin
            cnt_nxt = `PMCG_CNT_ZERO;
        end else if (tick_fall) begin
            cnt_nxt = cnt_r + `PMCG_CNT_ONE;
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    // Sequencer registers
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= S_ACTIVE;
            cnt_r <= `PMCG_CNT_ZERO;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Vector address register, loaded when the fetch starts
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            vec_r <= `PMCG_ADDR_RESET;
        end else if (nmi_fetch_nxt) begin
            vec_r <= `PMCG_NMI_VECTOR;
        end
    end

    // Gating is decoded from registered state so the enables cannot glitch
    // core frozen in idle
    assign core_clk_en = in_grp(state_r, G_CORE_ON);
    assign periph_clk_en = !in_grp(state_r, G_PERIPH_OFF);
    assign ready_cs_clk_en = periph_clk_en;
    assign clock_output = clock_output_r;

    // Oscillator: off once entry completes, restarted by the wake sequence
    // oscillator disabled later
    assign osc_enable = !(state_r == S_PD);
    assign osc_delay_pin = (state_r == S_PD_OSC);
    assign clock_input_isolate = in_grp(state_r, G_OSC_OFF);

    // Refresh counter steps on falling clock output while peripherals run
    // decrement on falling edge
    assign refresh_tick = tick_fall && periph_clk_en;
    assign refresh_go = ref_go_nxt;

    assign bus_hold_ack = (state_r == S_HOLD_ON) || (state_r == S_HOLD_END);

    // Interrupt strobes, one clk cycle each
    assign irq_acknowledge = irq_ack_nxt;
    assign nmi_to_core = nmi_pres_nxt;
    assign nmi_vector_fetch = nmi_fetch_nxt;
    assign nmi_vector_addr = vec_r;

    // Mode and register views
    assign mode_idle = in_grp(state_r, G_IDLE);
    assign mode_powerdown = in_grp(state_r, G_PERIPH_OFF);
    assign power_control_reg = pcr_r;

endmodule

//--- pmcg_consts.vh
// Constants for the power mode and clock gating block.
// Assumes it is included by bare name from the block's design file.
`ifndef PMCG_CONSTS_VH
`define PMCG_CONSTS_VH

// Power control register layout
`define PMCG_PCR_W 2
`define PMCG_ARM_IDLE_BIT 0
`define PMCG_ARM_PD_BIT 1
`define PMCG_PCR_RESET 2'h0
`define PMCG_ARM_IDLE_ONLY 2'h1
`define PMCG_ARM_PD_ONLY 2'h2

// Sequence lengths, in clock output cycles
`define PMCG_CNT_W 4
`define PMCG_CNT_ZERO 4'h0
`define PMCG_CNT_ONE 4'h1
`define PMCG_IRQ_START_CYC 4'h7
`define PMCG_IRQ_RESP_CYC 4'h6
`define PMCG_NMI_START_CYC 4'h2
`define PMCG_NMI_RESP_CYC 4'h6
`define PMCG_IDLE_TSTATE_CYC 4'h1
`define PMCG_HOLD_START_CYC 4'h1
`define PMCG_HOLD_ACK_CYC 4'h1
`define PMCG_HOLD_END_CYC 4'h1
`define PMCG_PD_RUN_CYC 4'h1
`define PMCG_PD_PRESENT_CYC 4'h2

// Vector address fetched for a non-maskable interrupt
`define PMCG_ADDR_W 20
`define PMCG_NMI_VECTOR 20'h0_0008
`define PMCG_ADDR_RESET 20'h0_0000

// Clock output divider
`define PMCG_DIV_W 4
`define PMCG_DIV_ZERO 4'h0
`define PMCG_DIV_ONE 4'h1
`define PMCG_CLOCK_OUTPUT_RESET 1'b1

`endif

//--- pmcg_sva.sv
// Checker for the power mode sequencer, bound to the design's ports.
// Assumes one clock domain and the design constants header.
`include "pmcg_consts.vh"
module pmcg_sva #(
    parameter [3:0] CLOCK_OUTPUT_HALF = 4'h1
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Core side
    input wire halt_t2,
    input wire pcr_wr,
    input wire [`PMCG_PCR_W-1:0] pcr_wdata,
    input wire [`PMCG_PCR_W-1:0] power_control_reg,
    // Gating and oscillator
    input wire core_clk_en,
    input wire periph_clk_en,
    input wire ready_cs_clk_en,
    input wire clock_output,
    input wire osc_enable,
    input wire clock_input_isolate,
    // Bus, refresh, interrupts, modes
    input wire refresh_go,
    input wire bus_hold_ack,
    input wire irq_acknowledge,
    input wire nmi_to_core,
    input wire nmi_vector_fetch,
    input wire [`PMCG_ADDR_W-1:0] nmi_vector_addr,
    input wire mode_idle,
    input wire mode_powerdown
);
    // Six clock output periods, in clk cycles
    localparam int FETCH_GAP = 12 * CLOCK_OUTPUT_HALF;
    // Core and peripherals clocked, not idle or powerdown: the active state, where a halt is taken, the interrupt response states and S_PD_NMI
    wire act = core_clk_en && periph_clk_en && !mode_idle && !mode_powerdown;
    wire [`PMCG_PCR_W-1:0] pcr = power_control_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    idle_from_halt_a: assert property ($rose(mode_idle) |-> $past(halt_t2))
        else $error("idle entered without halt");
    idle_entry_a: assert property (halt_t2 && act && pcr == `PMCG_ARM_IDLE_ONLY
        |=> mode_idle && !core_clk_en && periph_clk_en)
        else $error("idle halt did not gate core only");
    halt_default_a: assert property (halt_t2 && act && (pcr == 2'h0 || pcr == 2'h3)
        |=> act)
        else $error("halt left active mode");
    pd_entry_a: assert property (halt_t2 && act && pcr == `PMCG_ARM_PD_ONLY
        |=> !core_clk_en && !periph_clk_en)
        else $error("powerdown halt left clocks running");
    pd_parked_a: assert property (!osc_enable
        |-> clock_output && clock_input_isolate && !periph_clk_en)
        else $error("clock output or isolation wrong in powerdown");
    pd_quiet_a: assert property (mode_powerdown |-> !bus_hold_ack && !refresh_go)
        else $error("hold or refresh served in powerdown");
    idle_periph_a: assert property (mode_idle |-> periph_clk_en && ready_cs_clk_en)
        else $error("peripheral clock stopped in idle");
    hold_ack_a: assert property ($rose(bus_hold_ack) |-> $past(core_clk_en))
        else $error("hold acknowledge before core clock");
    refresh_ack_a: assert property (refresh_go |=> !bus_hold_ack)
        else $error("refresh started with hold acknowledged");
    pcr_write_a: assert property (pcr_wr |=> pcr == $past(pcr_wdata))
        else $error("power control write lost");
    pcr_keep_a: assert property (!pcr_wr |=> $stable(pcr))
        else $error("power control changed without write");
    nmi_fetch_a: assert property (nmi_to_core |-> ##FETCH_GAP nmi_vector_fetch)
        else $error("vector fetch not six periods after presentation");
    nmi_addr_a: assert property (nmi_vector_fetch
        |=> nmi_vector_addr == `PMCG_NMI_VECTOR)
        else $error("wrong vector address");
    irq_exit_a: assert property (irq_acknowledge |-> core_clk_en ##1 !mode_idle)
        else $error("interrupt acknowledge without active core");
    // Main scenarios reached
    idle_c: cover property ($rose(mode_idle));
    pd_c: cover property ($fell(osc_enable));
    hold_c: cover property ($rose(bus_hold_ack));
    irq_c: cover property (irq_acknowledge);
    nmi_c: cover property (nmi_vector_fetch);
endmodule

bind pmcg_power_mode_clock_gating pmcg_sva #(.CLOCK_OUTPUT_HALF(CLOCK_OUTPUT_HALF)) u_sva (
    .clk, .rstn, .halt_t2, .pcr_wr, .pcr_wdata, .power_control_reg, .core_clk_en,
    .periph_clk_en, .ready_cs_clk_en, .clock_output, .osc_enable, .clock_input_isolate,
    .refresh_go, .bus_hold_ack, .irq_acknowledge, .nmi_to_core, .nmi_vector_fetch,
    .nmi_vector_addr, .mode_idle, .mode_powerdown);

//--- pmcg_far_model.sv
// Far side model: refresh unit with wait states and the crystal oscillator.
// Assumes clk runs throughout and the bench enables refresh requests.
module pmcg_far_model #(
    parameter int WAITS = 3,
    parameter int OSC_DLY = 40
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Refresh unit
    input wire refresh_en,
    input wire refresh_tick,
    input wire refresh_go,
    output logic refresh_req,
    output logic refresh_done,
    // Oscillator
    input wire osc_enable,
    output logic oscillator_stable
);
    int down_r; // Refresh down counter
    int bus_r; // Refresh bus cycle countdown
    int osc_r; // Cycles since oscillator enabled
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            down_r <= 3;
            bus_r <= 0;
            refresh_req <= 1'b0;
            refresh_done <= 1'b0;
        end else begin
            // Done pulse as the last T-state ends
            refresh_done <= (bus_r == 1);
            if (bus_r > 0)
                bus_r <= bus_r - 1;
            if (refresh_go) begin
                refresh_req <= 1'b0;
                bus_r <= 2 * (4 + WAITS);
            end else if (refresh_tick && refresh_en && !refresh_req && bus_r == 0) begin
                if (down_r == 0) begin
                    refresh_req <= 1'b1;
                    down_r <= 3;
                end else begin
                    down_r <= down_r - 1;
                end
            end
        end
    end
    // Oscillator settles only while its inverter runs
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            osc_r <= OSC_DLY;
        else
            osc_r <= osc_enable ? osc_r + 1 : 0;
    end
    assign oscillator_stable = osc_r >= OSC_DLY;
endmodule

//--- pmcg_power_mode_clock_gating_test.sv
// Self-checking bench for the power mode sequencer.
// Assumes the design, far side model and checker are compiled before it.
`include "pmcg_consts.vh"
module pmcg_power_mode_clock_gating_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rstn = 1'b0, halt_t2 = 1'b0, pcr_wr = 1'b0, refresh_en = 1'b0;
    logic bus_hold_req = 1'b0, irq_unmasked_req = 1'b0, nmi_req = 1'b0;
    logic [1:0] pcr_wdata = 2'h0;
    logic [15:0] lfsr_r = 16'h2baf; // Random source
    wire [1:0] pcr;
    wire [19:0] vaddr;
    wire core_clk_en, periph_clk_en, ready_cs_clk_en, clock_output, osc_enable, osc_delay_pin;
    wire clock_input_isolate, oscillator_stable, refresh_tick, refresh_req, refresh_go;
    wire refresh_done, bus_hold_ack, irq_acknowledge, nmi_to_core, nmi_vector_fetch;
    wire mode_idle, mode_powerdown;
    int n_errors = 0, samples_checked = 0, cyc_cnt = 0;
    int exp_pcr; // Model of the arming bits
    always #2 clk = ~clk;
    pmcg_power_mode_clock_gating #(.CLOCK_OUTPUT_HALF(4'h1)) DUT (.clk(clk), .rstn(rstn),
        .halt_t2(halt_t2), .pcr_wr(pcr_wr), .pcr_wdata(pcr_wdata), .power_control_reg(pcr),
        .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
        .ready_cs_clk_en(ready_cs_clk_en), .clock_output(clock_output),
        .osc_enable(osc_enable), .osc_delay_pin(osc_delay_pin),
        .clock_input_isolate(clock_input_isolate), .oscillator_stable(oscillator_stable),
        .refresh_tick(refresh_tick), .refresh_req(refresh_req), .refresh_go(refresh_go),
        .refresh_done(refresh_done), .bus_hold_req(bus_hold_req), .bus_hold_ack(bus_hold_ack),
        .irq_unmasked_req(irq_unmasked_req), .irq_acknowledge(irq_acknowledge),
        .nmi_req(nmi_req), .nmi_to_core(nmi_to_core), .nmi_vector_fetch(nmi_vector_fetch),
        .nmi_vector_addr(vaddr), .mode_idle(mode_idle), .mode_powerdown(mode_powerdown));
    pmcg_far_model FAR (.clk(clk), .rstn(rstn), .refresh_en(refresh_en),
        .refresh_tick(refresh_tick), .refresh_go(refresh_go), .refresh_req(refresh_req),
        .refresh_done(refresh_done), .osc_enable(osc_enable),
        .oscillator_stable(oscillator_stable));
    // Verdict and end of run
    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Random source step, taps for a maximal length sequence
    function automatic logic [15:0] lfsr_step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Land just after an edge so outputs are settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic hit(input int sel);
        case (sel)
            0: hit = core_clk_en === 1'b1;
            1: hit = bus_hold_ack === 1'b1;
            2: hit = bus_hold_ack === 1'b0;
            3: hit = osc_enable === 1'b0;
            4: hit = nmi_to_core === 1'b1;
            5: hit = irq_acknowledge === 1'b1;
            6: hit = refresh_go === 1'b1;
            7: hit = nmi_vector_fetch === 1'b1;
            default: hit = core_clk_en === 1'b0;
        endcase
    endfunction
    // Bounded wait, cycles counted in n
    task automatic wait_on(input int sel, output int n);
        n = 0;
        while (!hit(sel) && n < 200) begin
            cyc(1);
            n++;
        end
        if (n >= 200)
            chk("wait", sel, 32'hffff_ffff);
    endtask
    task automatic wr_pcr(input logic [1:0] d);
        pcr_wr <= 1'b1;
        pcr_wdata <= d;
        cyc(1);
        pcr_wr <= 1'b0;
        exp_pcr = d;
        cyc(1);
        chk("pcr", pcr, exp_pcr);
    endtask
    task automatic halt();
        halt_t2 <= 1'b1;
        cyc(1);
        halt_t2 <= 1'b0;
        cyc(1);
    endtask
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    initial begin
        int n;
        int t;
        exp_pcr = 0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        cyc(1);
        chk("rst", {pcr, core_clk_en, periph_clk_en, osc_enable, clock_output}, 6'h0e);
        for (int i = 0; i < 6; i++) begin
            lfsr_r = lfsr_step(lfsr_r);
            wr_pcr(i < 2 ? 2'(i * 3) : lfsr_r[1:0]);
            chk("armed", {mode_idle, mode_powerdown}, 2'h0);
            if (exp_pcr == 0 || exp_pcr == 3) begin
                halt();
                chk("dflt", {core_clk_en, periph_clk_en, mode_idle}, 3'h6);
            end
        end
        wr_pcr(2'h1);
        halt();
        chk("idle", {mode_idle, core_clk_en, periph_clk_en}, 3'h5);
        t = 0;
        repeat (20) begin
            cyc(1);
            t += refresh_tick;
        end
        chk("ticks", t, 10);
        refresh_en <= 1'b1;
        wait_on(0, n);
        wait_on(6, n);
        chk("rf_gap", n, 1);
        refresh_en <= 1'b0;
        wait_on(8, n);
        chk("rf_end", mode_idle, 1'b1);
        bus_hold_req <= 1'b1;
        wait_on(0, n);
        wait_on(1, n);
        chk("ack_gap", n, 2);
        refresh_en <= 1'b1;
        wait_on(6, n);
        cyc(1);
        chk("rf_hold", bus_hold_ack, 1'b0);
        refresh_en <= 1'b0;
        wait_on(1, n);
        bus_hold_req <= 1'b0;
        wait_on(8, n);
        chk("hold_end", {bus_hold_ack, mode_idle}, 2'h1);
        irq_unmasked_req <= 1'b1;
        wait_on(0, n);
        chk("irq_start", n >= 12 && n <= 15, 1'b1);
        wait_on(5, n);
        chk("irq_ack", n, 11);
        irq_unmasked_req <= 1'b0;
        cyc(10);
        chk("irq_exit", {mode_idle, core_clk_en, pcr}, exp_pcr | 4);
        halt();
        chk("re_idle", mode_idle, 1'b1);
        nmi_req <= 1'b1;
        wait_on(4, n);
        nmi_req <= 1'b0;
        cyc(1);
        chk("nmi_core", core_clk_en, 1'b1);
        wait_on(7, n);
        chk("nmi_fetch", n, 11);
        cyc(1);
        chk("nmi_exit", {vaddr, mode_idle, pcr}, {`PMCG_NMI_VECTOR, 3'h1});
        wr_pcr(2'h2);
        halt();
        chk("pd", {core_clk_en, periph_clk_en, mode_powerdown}, 3'h1);
        wait_on(3, n);
        chk("osc_off", n <= 4, 1'b1);
        bus_hold_req <= 1'b1;
        t = 0;
        repeat (20) begin
            cyc(1);
            t += clock_output & clock_input_isolate & !bus_hold_ack & !refresh_tick;
        end
        bus_hold_req <= 1'b0;
        chk("pd_still", t, 20);
        nmi_req <= 1'b1;
        cyc(6);
        chk("osc_wait", {osc_enable, osc_delay_pin, core_clk_en}, 3'h6);
        wait_on(0, t);
        wait_on(4, n);
        nmi_req <= 1'b0;
        chk("pd_nmi", n, 3);
        wait_on(7, n);
        chk("pd_fetch", n, 12);
        chk("pd_exit", {mode_powerdown, pcr}, exp_pcr);
        wr_pcr(2'h1);
        halt();
        rstn <= 1'b0;
        cyc(2);
        rstn <= 1'b1;
        cyc(1);
        chk("rst_idle", {pcr, mode_idle, core_clk_en}, 4'h1);
        finish_test();
    end
endmodule
